// ===== design/sbcwd_pkg.sv
package sbcwd_pkg;
  // register byte addresses on the AHB-Lite slave
  localparam logic [7:0] ADDR_WDSVC = 8'h00;
  localparam logic [7:0] ADDR_WAKECTL = 8'h04;
  localparam logic [7:0] ADDR_PEND = 8'h08;
  localparam logic [7:0] ADDR_CHIP = 8'h0C;
  // service register fields
  localparam int WMB_POS = 3;
  localparam int PSEL_LSB = 0;
  localparam int PSEL_W = 3;
  localparam logic [2:0] PSEL_RST = 3'h4;
  localparam logic WMB_RST = 1'b0;
  // pending flag register fields
  localparam int LOCK_POS = 12;
  localparam int MLOW_POS = 11;
  localparam int TLOW_POS = 10;
  localparam int CYC_POS = 7;
  localparam int WK1_POS = 6;
  localparam int PWR_POS = 5;
  localparam int WK2_POS = 4;
  localparam int BUSW_POS = 3;
  localparam logic [15:0] PEND_RST = 16'h0020;
  localparam logic [15:0] FLAG_MASK = 16'h0CF8;
  // wake sampling control fields
  localparam int WS1_POS = 1;
  localparam int WS2_POS = 0;
  localparam int BRS_POS = 2;
  localparam logic [15:0] WAKECTL_RST = 16'h0000;
  localparam logic [15:0] WAKECTL_MASK = 16'h0007;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int BIAS_FAST_MS = 16;
  localparam int BIAS_SLOW_MS = 64;
  localparam int PERIOD_DEF_MS = 128;
  // chip operating modes
  localparam logic [2:0] CM_OFF = 3'h0;
  localparam logic [2:0] CM_OVT = 3'h1;
  localparam logic [2:0] CM_SLEEP = 3'h2;
  localparam logic [2:0] CM_STBY = 3'h3;
  localparam logic [2:0] CM_NORM = 3'h4;
  typedef enum logic [1:0] {SBCWD_OFF, SBCWD_WIN, SBCWD_TMO} sbcwd_mode_t;
  typedef struct packed {
    logic main_low;
    logic trx_low;
    logic bus_wake;
  } sbcwd_evt_t;
  // period_select code to milliseconds; code 4 gives 128 ms
  function automatic logic [12:0] sbcwd_period_ms(input logic [2:0] sel);
    sbcwd_period_ms = 13'(13'h0008 << sel);
  endfunction
endpackage

// ===== design/sbcwd_top.sv
`timescale 1ns/1ps
// What this block does
// - timing from own free-running oscillator
// - three modes, selectable period, 128 ms default
// - any service register write restarts timer
// - window mode early service resets system
// - window mode overflow resets system
// - late or timeout-mode service restarts timer
// - window mode: pin low, normal, bit 0
// - timeout overflow sets cyclic flag, else reset
// - timeout mode: standby/0 or normal/1
// - off in off/overtemp/sleep, standby/1, pin high
// - disable pin change in normal/standby resets
// - mode bit change in normal resets
// - watchdog reset reloads period select 100
// - pending interrupt re-enables standby-disabled watchdog
// - standby mode-bit write ignored while pending
// - pending flags cleared by writing one
// - bit 12 selects read-only lock
// - supply low flags 11, 10; cyclic 7
// - wake pin flags at 6 and 4
// - power-up flag reads 1 after reset
// - bus wake at 3; reserved bits zero
// - wake sampling continuous or bias-synchronised
// - mode field upper bit one means normal
// - watchdog resets always short pulse
module sbcwd_top
  import sbcwd_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic WATCHDOG_DISABLE_PIN,
  input wire logic WAKE_INPUT_ONE,
  input wire logic WAKE_INPUT_TWO,
  input wire sbcwd_evt_t EVT,
  output logic WAKE_BIAS_OUTPUT,
  output logic WD_RESET_REQ,
  output logic WD_RESET_SHORT,
  output logic [1:0] WD_MODE
);

  logic [2:0] period_select_r;
  logic watchdog_mode_bit_r;
  logic [2:0] chip_operating_mode_r;
  logic [15:0] wakectl_r;
  logic [15:0] pend_r;
  logic [15:0] pend_nxt;
  logic off_by_bit_r;
  logic pin_q_r;
  logic pin_seen_r;
  logic [17:0] tick_cnt_r;
  logic [12:0] ms_cnt_r;
  logic [6:0] bias_cnt_r;
  logic bias_r;
  logic wk1_q_r;
  logic wk2_q_r;
  logic reset_pulse_r;
  logic [1:0] mode_out_r;
  sbcwd_mode_t mode_prev_r;
  logic dph_r;
  logic dph_wr_r;
  logic [7:0] dph_addr_r;
  logic [31:0] hrdata_r;
  logic ready_r;
  logic resp_r;

  // write strobe of one register, in the data phase of a write
  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = dph_r && dph_wr_r && (dph_addr_r == a);
  endfunction

  // level change only once a first sample exists, so reset makes no false edge
  function automatic logic lvl_edge(input logic armed, input logic smp, input logic now, input logic was);
    lvl_edge = armed && smp && (now != was);
  endfunction

  // AHB-Lite address phase capture, zero wait states
  wire ap_valid = HSEL && HREADY && HTRANS[1];
  wire wr_svc = wr_hit(ADDR_WDSVC);
  wire wr_wake = wr_hit(ADDR_WAKECTL);
  wire wr_pend = wr_hit(ADDR_PEND);
  wire wr_chip = wr_hit(ADDR_CHIP);
  wire lock = pend_r[LOCK_POS];

  wire in_normal = chip_operating_mode_r[2];
  wire in_stby = (chip_operating_mode_r == CM_STBY);
  wire any_pend = |(pend_r & FLAG_MASK);
  wire new_wmb = HWDATA[WMB_POS];
  // standby mode-bit writes are dropped while anything is pending
  wire wmb_block = in_stby && any_pend && (new_wmb != watchdog_mode_bit_r);
  wire wmb_take = wr_svc && !wmb_block;
  wire wmb_changed = wmb_take && (new_wmb != watchdog_mode_bit_r);

  // mode selection
  wire pin_hi = WATCHDOG_DISABLE_PIN;
  wire sel_win = !pin_hi && in_normal && !watchdog_mode_bit_r;
  wire sel_tmo = !pin_hi && ((in_stby && !watchdog_mode_bit_r) ||
                 (in_normal && watchdog_mode_bit_r) ||
                 (in_stby && watchdog_mode_bit_r && !off_by_bit_r));
  sbcwd_mode_t mode_now;
  assign mode_now = sel_win ? SBCWD_WIN : (sel_tmo ? SBCWD_TMO : SBCWD_OFF);

  // millisecond tick from the local oscillator
  wire ms_tick = (tick_cnt_r == 18'(TICK_CYC - 1));
  wire [12:0] period_ms = sbcwd_period_ms(period_select_r);
  wire [12:0] half_ms = period_ms >> 1;
  wire overflow = ms_tick && (ms_cnt_r == 13'(period_ms - 13'h0001)) && (mode_now != SBCWD_OFF);
  wire early = wr_svc && (mode_now == SBCWD_WIN) && (ms_cnt_r < half_ms);
  wire mode_chg = (mode_now != mode_prev_r);
  wire restart = wr_svc || mode_chg || (mode_now == SBCWD_OFF);

  // disable pin change: only after the pin level has been caught once
  wire pin_chg = pin_seen_r && (pin_q_r != pin_hi) && (in_normal || in_stby);
  wire wmb_rst = wmb_changed && in_normal;
  wire win_ovf = overflow && (mode_now == SBCWD_WIN);
  wire tmo_ovf = overflow && (mode_now == SBCWD_TMO);
  wire tmo_rst = tmo_ovf && pend_r[CYC_POS];
  wire wd_rst = early || win_ovf || tmo_rst || pin_chg || wmb_rst;

  // wake sampling: continuous or only during bias pulses
  wire smp1 = !wakectl_r[WS1_POS] || bias_r;
  wire smp2 = !wakectl_r[WS2_POS] || bias_r;
  wire [6:0] bias_top = wakectl_r[BRS_POS] ? 7'(BIAS_SLOW_MS - 1) : 7'(BIAS_FAST_MS - 1);
  wire bias_wrap = ms_tick && (bias_cnt_r >= bias_top);
  wire wk1_edge = lvl_edge(pin_seen_r, smp1, WAKE_INPUT_ONE, wk1_q_r);
  wire wk2_edge = lvl_edge(pin_seen_r, smp2, WAKE_INPUT_TWO, wk2_q_r);

  // flag set wins over a same-cycle write-one clear
  logic [15:0] set_v;
  logic [15:0] clr_v;
  always_comb begin
    set_v = 16'h0000;
    set_v[MLOW_POS] = EVT.main_low;
    set_v[TLOW_POS] = EVT.trx_low;
    set_v[CYC_POS] = tmo_ovf && !pend_r[CYC_POS];
    set_v[WK1_POS] = wk1_edge;
    set_v[WK2_POS] = wk2_edge;
    set_v[BUSW_POS] = EVT.bus_wake;
    clr_v = (wr_pend && !lock) ? (HWDATA[15:0] & FLAG_MASK) : 16'h0000;
    pend_nxt = ((pend_r & ~clr_v) | set_v) & FLAG_MASK;
    if (wr_pend) begin
      pend_nxt[LOCK_POS] = HWDATA[LOCK_POS];
    end else begin
      pend_nxt[LOCK_POS] = lock;
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    unique case (HADDR[7:0])
      ADDR_WDSVC: rd_mux = {28'h0000000, watchdog_mode_bit_r, period_select_r};
      ADDR_WAKECTL: rd_mux = {16'h0000, wakectl_r};
      ADDR_PEND: rd_mux = {16'h0000, pend_r};
      ADDR_CHIP: rd_mux = {29'h0, chip_operating_mode_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dph_r <= 1'b0;
    end else begin
      dph_r <= ap_valid;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dph_wr_r <= 1'b0;
    end else begin
      dph_wr_r <= ap_valid && HWRITE;
    end
  end

  // address kept every cycle; only a qualified data phase acts on it
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dph_addr_r <= 8'h00;
    end else begin
      dph_addr_r <= HADDR[7:0];
    end
  end

  // read data leaves a flop: captured at the address-phase edge, so a read
  // straight behind a write to the same register returns the old value
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      hrdata_r <= 32'h00000000;
    end else if (ap_valid && !HWRITE) begin
      hrdata_r <= rd_mux;
    end else begin
      hrdata_r <= 32'h00000000;
    end
  end

  // zero wait states and OKAY only, still driven from flops
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ready_r <= 1'b1;
      resp_r <= 1'b0;
    end else begin
      ready_r <= 1'b1;
      resp_r <= 1'b0;
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = ready_r;
  assign HRESP = resp_r;

  // service register: period select, reloaded by any watchdog reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      period_select_r <= PSEL_RST;
    end else if (wd_rst) begin
      period_select_r <= PSEL_RST;
    end else if (wr_svc) begin
      period_select_r <= HWDATA[PSEL_LSB +: PSEL_W];
    end
  end

  // mode bit still follows a write that itself causes the reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      watchdog_mode_bit_r <= WMB_RST;
    end else if (wmb_take) begin
      watchdog_mode_bit_r <= new_wmb;
    end
  end

  // off_by_bit: standby-disabled watchdog, cleared by any pending flag
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      off_by_bit_r <= 1'b0;
    end else if (any_pend) begin
      off_by_bit_r <= 1'b0;
    end else if (wmb_take && in_stby) begin
      off_by_bit_r <= new_wmb;
    end else if (!in_stby) begin
      off_by_bit_r <= watchdog_mode_bit_r;
    end
  end

  // lock blocks wake control writes as well as flag clears
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wakectl_r <= WAKECTL_RST;
    end else if (wr_wake && !lock) begin
      wakectl_r <= HWDATA[15:0] & WAKECTL_MASK;
    end
  end

  // set wins over clear inside pend_nxt
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_r <= PEND_RST;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // chip mode stands in for the mode controller outside this block
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      chip_operating_mode_r <= CM_STBY;
    end else if (wr_chip) begin
      chip_operating_mode_r <= HWDATA[2:0];
    end
  end

  // timers
  // tick runs free in every watchdog mode, so the bias rate never stalls
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tick_cnt_r <= 18'h00000;
    end else begin
      tick_cnt_r <= ms_tick ? 18'h00000 : 18'(tick_cnt_r + 18'h00001);
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ms_cnt_r <= 13'h0000;
    end else if (restart || overflow) begin
      ms_cnt_r <= 13'h0000;
    end else if (ms_tick) begin
      ms_cnt_r <= 13'(ms_cnt_r + 13'h0001);
    end
  end

  // off after reset, so the first selected mode starts a fresh period
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_prev_r <= SBCWD_OFF;
    end else begin
      mode_prev_r <= mode_now;
    end
  end

  // bias pulse is one ms wide at the start of each bias interval
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bias_cnt_r <= 7'h00;
    end else if (bias_wrap) begin
      bias_cnt_r <= 7'h00;
    end else if (ms_tick) begin
      bias_cnt_r <= 7'(bias_cnt_r + 7'h01);
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bias_r <= 1'b0;
    end else if (ms_tick) begin
      bias_r <= bias_wrap;
    end
  end

  // a held sample keeps its level while sampling waits for the bias pulse
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wk1_q_r <= 1'b0;
    end else if (smp1) begin
      wk1_q_r <= WAKE_INPUT_ONE;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wk2_q_r <= 1'b0;
    end else if (smp2) begin
      wk2_q_r <= WAKE_INPUT_TWO;
    end
  end

  // pin_seen also arms the wake edge detectors
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_q_r <= 1'b0;
      pin_seen_r <= 1'b0;
    end else begin
      pin_q_r <= pin_hi;
      pin_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      reset_pulse_r <= 1'b0;
    end else begin
      reset_pulse_r <= wd_rst;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_out_r <= 2'h0;
    end else begin
      mode_out_r <= mode_now;
    end
  end

  assign WD_RESET_REQ = reset_pulse_r;
  assign WD_RESET_SHORT = reset_pulse_r;
  assign WAKE_BIAS_OUTPUT = bias_r;
  assign WD_MODE = mode_out_r;

endmodule // sbcwd_top

// ===== testbench/sbcwd_props.sv
`timescale 1ns/1ps
module sbcwd_props
  import sbcwd_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic WATCHDOG_DISABLE_PIN,
  input wire logic WD_RESET_REQ,
  input wire logic WD_RESET_SHORT,
  input wire logic [1:0] WD_MODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence rd_addr;
    HSEL && HREADY && HTRANS[1] && !HWRITE;
  endsequence
  sequence pend_rd;
    rd_addr ##0 HADDR[7:0] == ADDR_PEND;
  endsequence
  sequence hole_rd;
    rd_addr ##0 HADDR[7:0] > ADDR_CHIP;
  endsequence
  ready_high_a: assert property (HREADYOUT) else $error("slave stalled");
  resp_okay_a: assert property (!HRESP) else $error("error response");
  short_pulse_a: assert property (WD_RESET_REQ == WD_RESET_SHORT) else $error("reset not short");
  pulse_one_a: assert property (WD_RESET_REQ |=> !WD_RESET_REQ) else $error("reset pulse too long");
  mode_legal_a: assert property (WD_MODE != 2'h3) else $error("bad watchdog mode");
  pin_off_a: assert property (WATCHDOG_DISABLE_PIN [*4] |-> WD_MODE == SBCWD_OFF) else $error("pin off ignored");
  pin_change_a: assert property ($rose(WATCHDOG_DISABLE_PIN) && WD_MODE != SBCWD_OFF |-> ##[1:4] WD_RESET_REQ)
    else $error("pin change no reset");
  reserved_zero_a: assert property (pend_rd |=> HRDATA[31:16] == 16'h0000 && HRDATA[9:8] == 2'h0 && HRDATA[2:0] == 3'h0)
    else $error("reserved bits set");
  unmapped_zero_a: assert property (hole_rd |=> HRDATA == 32'h00000000) else $error("unmapped read not zero");
endmodule // sbcwd_props

// ===== testbench/sbcwd_host.sv
`timescale 1ns/1ps
module sbcwd_host (
  input wire logic CLK,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  output logic HSEL = 1'h0,
  output logic [31:0] HADDR = 32'h0,
  output logic [1:0] HTRANS = 2'h0,
  output logic HWRITE = 1'h0,
  output logic [2:0] HSIZE = 3'h2,
  output logic [31:0] HWDATA = 32'h0
);
  // hready and read data are taken at the rising edge that ends each phase
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLK);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HADDR <= {24'h000000, a};
    HWRITE <= we;
    do begin
      @(posedge CLK);
    end while (HREADY !== 1'h1);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do begin
      @(posedge CLK);
      rd = HRDATA;
    end while (HREADY !== 1'h1);
  endtask
endmodule // sbcwd_host

// ===== testbench/sbcwd_top_tb.sv
`timescale 1ns/1ps
module sbcwd_top_tb
  import sbcwd_pkg::*;
;
  typedef struct packed {logic we; logic [7:0] a; logic [31:0] d;} sbcwd_row_t;
  localparam sbcwd_row_t rows [9] = '{'{1'h0, ADDR_WDSVC, 32'h4}, '{1'h0, ADDR_WAKECTL, 32'h0},
    '{1'h0, ADDR_PEND, 32'h20}, '{1'h0, ADDR_CHIP, 32'h3}, '{1'h1, ADDR_WAKECTL, 32'h7},
    '{1'h0, ADDR_WAKECTL, 32'h7}, '{1'h1, ADDR_WAKECTL, 32'h0}, '{1'h1, 8'h10, 32'hFFFF}, '{1'h0, 8'h10, 32'h0}};
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic pin = 1'h0;
  logic wk1 = 1'h0;
  logic wk2 = 1'h0;
  sbcwd_evt_t evt = '0;
  wire logic hsel, hwrite, hready, hresp, wake_bias_output, rreq, rshort;
  wire logic [1:0] htrans, wmode;
  wire logic [2:0] hsize;
  wire logic [31:0] haddr, hwdata, hrdata;
  int num_errors = 0;
  int num_checks = 0;
  int nrst = 0;
  sbcwd_top u_sbcwd_top (.CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .WATCHDOG_DISABLE_PIN(pin), .WAKE_INPUT_ONE(wk1), .WAKE_INPUT_TWO(wk2), .EVT(evt), .WAKE_BIAS_OUTPUT(wake_bias_output),
    .WD_RESET_REQ(rreq), .WD_RESET_SHORT(rshort), .WD_MODE(wmode));
  sbcwd_host u_sbcwd_host (.CLK(clk), .HREADY(hready), .HRDATA(hrdata), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) nrst <= nrst + int'(rreq === 1'h1);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_sbcwd_host.xfer(1'h1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    u_sbcwd_host.xfer(1'h0, a, 32'h0, x);
    chk(x, e);
  endtask
  // counts pulses, so a double reset shows as well as a missing one
  task automatic rst_exp(input int n);
    int b;
    #1;
    b = nrst;
    repeat (8) @(posedge clk);
    #1;
    chk(32'(nrst - b), 32'(n));
  endtask
  task automatic md(input sbcwd_mode_t m);
    repeat (4) @(posedge clk);
    #1;
    chk(32'(wmode), 32'(m));
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #40000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    md(SBCWD_TMO);
    foreach (rows[i]) if (rows[i].we) wr(rows[i].a, rows[i].d); else rd(rows[i].a, rows[i].d);
    @(posedge clk);
    evt <= '1;
    @(posedge clk);
    evt <= '0;
    wk1 <= 1'h1;
    wk2 <= 1'h1;
    repeat (6) @(posedge clk);
    rd(ADDR_PEND, 32'h0C78);
    wr(ADDR_WDSVC, 32'hC);
    rst_exp(0);
    md(SBCWD_TMO);
    rd(ADDR_WDSVC, 32'h4);
    wr(ADDR_PEND, 32'h0400);
    rd(ADDR_PEND, 32'h0878);
    wr(ADDR_PEND, 32'h1000);
    wr(ADDR_PEND, 32'h1800);
    rd(ADDR_PEND, 32'h1878);
    wr(ADDR_PEND, 32'h0);
    wr(ADDR_PEND, 32'(FLAG_MASK));
    rd(ADDR_PEND, 32'h0);
    wr(ADDR_WDSVC, 32'hC);
    md(SBCWD_OFF);
    @(posedge clk);
    evt.bus_wake <= 1'h1;
    @(posedge clk);
    evt <= '0;
    md(SBCWD_TMO);
    wr(ADDR_PEND, 32'(FLAG_MASK));
    wr(ADDR_WDSVC, 32'h4);
    wr(ADDR_CHIP, 32'h7);
    md(SBCWD_WIN);
    // early service with a new period: reset must also restore the default code
    wr(ADDR_WDSVC, 32'h0);
    rst_exp(1);
    rd(ADDR_WDSVC, 32'h4);
    wr(ADDR_WDSVC, 32'hC);
    md(SBCWD_TMO);
    wr(ADDR_WDSVC, 32'hD);
    rst_exp(0);
    wr(ADDR_WDSVC, 32'h4);
    rst_exp(1);
    md(SBCWD_WIN);
    @(posedge clk);
    pin <= 1'h1;
    rst_exp(1);
    md(SBCWD_OFF);
    @(posedge clk);
    pin <= 1'h0;
    rst_exp(1);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CHIP, 32'(m));
      md(SBCWD_OFF);
    end
    @(posedge clk);
    rst_b <= 1'h0;
    @(posedge clk);
    rst_b <= 1'h1;
    rd(ADDR_PEND, 32'h20);
    md(SBCWD_TMO);
    chk(32'(wake_bias_output), 32'h0);
    complete_run();
  end
endmodule // sbcwd_top_tb
bind sbcwd_top sbcwd_props u_sbcwd_props (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .WATCHDOG_DISABLE_PIN(WATCHDOG_DISABLE_PIN), .WD_RESET_REQ(WD_RESET_REQ), .WD_RESET_SHORT(WD_RESET_SHORT),
  .WD_MODE(WD_MODE));
